// >>> tcps_params.svh
// Contract
// (R1) clock config bits 7 and 2 read as zero, writes to them ignored
// (R2) bit 5 picks timer 2 low byte clock: 0 alternate clock, 1 system clock
// (R3) bit 6 picks timer 2 high byte clock: 0 alternate clock, 1 system clock
// (R4) bit 4 is the timer 1 clock select in timer mode
// (R5) timer 1 counts prescaled clock when bit 4 is 0, system clock when 1
// (R6) timer 0 counts the prescaled clock when its fast select is 0
// (R7) timer 0 counts every system clock when bit 3 is 1
// (R8) timer 0 fast select is ignored while timer 0 counts events; the split upper byte still uses it
// (R9) prescale code 00 divides by 12, 01 by 4, 10 by 48
// (R10) each of timers 0 and 1 has a 16-bit count as two byte registers
// (R11) one control register holds run enables and reports overflow flags
// (R12) each timer interrupt is gated by its own enable bit
// (R13) each of timers 0 and 1 runs in one of four modes from its mode bits; timer 1 stops counting in mode 11 instead
// (R14) timer 0 and timer 1 settings are written independently
// (R15) in counter mode a falling edge on the event pin increments the count; timer 1 counts its clock instead while timer 0 is split
// (R16) event sources hold each level at least two system clock periods
`ifndef TCPS_PARAMS_SVH
`define TCPS_PARAMS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define TCPS_OFF_CLKCFG   8'h00
`define TCPS_OFF_CTRL     8'h04
`define TCPS_OFF_MODE     8'h08
`define TCPS_OFF_IRQEN    8'h0c
`define TCPS_OFF_T0LO     8'h10
`define TCPS_OFF_T0HI     8'h14
`define TCPS_OFF_T1LO     8'h18
`define TCPS_OFF_T1HI     8'h1c

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define TCPS_CFG_T2H      6
`define TCPS_CFG_T2L      5
`define TCPS_CFG_T1FAST   4
`define TCPS_CFG_T0FAST   3
`define TCPS_CFG_WMASK    8'h7b
`define TCPS_CTRL_TR0     0
`define TCPS_CTRL_TF0     1
`define TCPS_CTRL_TR1     2
`define TCPS_CTRL_TF1     3
`define TCPS_MODE_T0CM    2
`define TCPS_MODE_T1CM    6
`define TCPS_MODE_WMASK   8'h77

// ----------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------
`define TCPS_RST_BYTE     8'h00
`define TCPS_DIV_CODE00   6'd12
`define TCPS_DIV_CODE01   6'd4
`define TCPS_DIV_CODE10   6'd48
`define TCPS_DIV_CODE11   6'd8

`endif

// >>> tcps_pkg.sv
package tcps_pkg;

  typedef enum logic [1:0]
  {
    TCPS_M13   = 2'b00,
    TCPS_M16   = 2'b01,
    TCPS_M8REL = 2'b10,
    TCPS_SPLIT = 2'b11
  } tcps_mode_t;

  typedef logic [1:0] tcps_psel_t;

endpackage

// >>> tcps_presc_if.sv
`timescale 1ns/10ps

interface tcps_presc_if;
  import tcps_pkg::*;
  tcps_psel_t sel;
  logic       tick;
  modport ctrl (output sel, input tick);
  modport div  (input sel, output tick);
endinterface

// >>> tcps_prescaler.sv
`timescale 1ns/10ps
`include "tcps_params.svh"

module tcps_prescaler
  import tcps_pkg::*;
(
  // clock and reset
  input wire logic   clk,
  input wire logic   nrst,
  // select and tick
  tcps_presc_if.div  pif
);

  logic [5:0] cnt_r;
  logic [5:0] cnt_nxt;
  logic       tick_r;
  logic [5:0] div_m1;
  logic       wrap;

  // code 11 is a spare divider so every code yields a defined rate
  assign div_m1 = (pif.sel == 2'b00) ? `TCPS_DIV_CODE00 - 6'd1 : // see (R9)
                  (pif.sel == 2'b01) ? `TCPS_DIV_CODE01 - 6'd1 :
                  (pif.sel == 2'b10) ? `TCPS_DIV_CODE10 - 6'd1 :
                                       `TCPS_DIV_CODE11 - 6'd1;
  // >= rather than == so a shrinking divisor never strands the count
  assign wrap    = (cnt_r >= div_m1);
  assign cnt_nxt = wrap ? 6'h00 : cnt_r + 6'h01;
  assign pif.tick = tick_r;

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      cnt_r  <= 6'h00;
      tick_r <= 1'b0;
    end
    else
    begin
      cnt_r  <= cnt_nxt;
      tick_r <= wrap;
    end
  end

  a_presc_period: assert property (@(posedge clk) disable iff (!nrst) // see (R9)
    (tick_r && pif.sel == 2'b01) ##1 (pif.sel == 2'b01)[*3] |=> tick_r)
    else $error("prescaler tick period wrong");

  a_presc_min_gap: assert property (@(posedge clk) disable iff (!nrst) // see (R9)
    tick_r |=> (!tick_r)[*3])
    else $error("prescaler ticks too close");

  a_presc_div_m1: assert property (@(posedge clk) disable iff (!nrst) // see (R9)
    (tick_r && pif.sel == 2'b10 && $past(pif.sel) == 2'b10)
      |-> $past(cnt_r) == `TCPS_DIV_CODE10 - 6'd1)
    else $error("prescaler tick at wrong count");

endmodule

// >>> tcps_top.sv
`timescale 1ns/10ps
`include "tcps_params.svh"

module tcps_top
  import tcps_pkg::*;
(
  // clock and reset
  input  wire logic        CLK_SYS,
  input  wire logic        NRST,
  // apb slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // event pins
  input  wire logic        TIMER0_EVENT_PIN,
  input  wire logic        TIMER1_EVENT_PIN,
  // timer 2 alternate clock enable
  input  wire logic        T2_ALT_TICK,
  // timer clock enables out
  output logic             T2L_TICK,
  output logic             T2H_TICK,
  output logic             T1_OVF,
  // interrupts
  output logic             IRQ_T0,
  output logic             IRQ_T1
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0]  cfg_r;
  logic [7:0]  mode_r;
  logic [1:0]  ie_r;
  logic        tr0_r, tr1_r, tf0_r, tf1_r;
  logic        tf0_nxt, tf1_nxt;
  logic [15:0] cnt0_r, cnt1_r;
  logic [15:0] cnt0_nxt, cnt1_nxt;
  logic        pready_r, pslverr_r;
  logic [31:0] prdata_r;
  logic        t2l_r, t2h_r, t1ovf_r, irq0_r, irq1_r;
  logic [1:0]  ev_s1, ev_s2, ev_s3;
  logic [1:0]  ev_fall;
  logic [1:0]  ev_pin;

  tcps_presc_if pif ();

  tcps_prescaler u_presc
  (
    .clk  (CLK_SYS),
    .nrst (NRST),
    .pif  (pif)
  );

  assign pif.sel = cfg_r[1:0]; // see (R9)

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  logic acc, wr_en, mapped;
  logic w_cfg, w_ctrl, w_mode, w_ie, w_t0l, w_t0h, w_t1l, w_t1h;
  logic [31:0] rd_mux;

  // one wait state: ready rises in the second access cycle
  assign acc    = PSEL & PENABLE & ~pready_r;
  assign wr_en  = PSEL & PENABLE & pready_r & PWRITE & ~pslverr_r;
  assign w_cfg  = wr_en & hit(PADDR, `TCPS_OFF_CLKCFG);
  assign w_ctrl = wr_en & hit(PADDR, `TCPS_OFF_CTRL);
  assign w_mode = wr_en & hit(PADDR, `TCPS_OFF_MODE);
  assign w_ie   = wr_en & hit(PADDR, `TCPS_OFF_IRQEN);
  assign w_t0l  = wr_en & hit(PADDR, `TCPS_OFF_T0LO);
  assign w_t0h  = wr_en & hit(PADDR, `TCPS_OFF_T0HI);
  assign w_t1l  = wr_en & hit(PADDR, `TCPS_OFF_T1LO);
  assign w_t1h  = wr_en & hit(PADDR, `TCPS_OFF_T1HI);
  assign mapped = (PADDR[7:5] == 3'b000) & (PADDR[1:0] == 2'b00);

  assign rd_mux =
    hit(PADDR, `TCPS_OFF_CLKCFG) ? {24'h000000, cfg_r} :
    hit(PADDR, `TCPS_OFF_CTRL)   ? {28'h0000000, tf1_r, tr1_r, tf0_r, tr0_r} : // see (R11)
    hit(PADDR, `TCPS_OFF_MODE)   ? {24'h000000, mode_r} :
    hit(PADDR, `TCPS_OFF_IRQEN)  ? {30'h0, ie_r} :
    hit(PADDR, `TCPS_OFF_T0LO)   ? {24'h000000, cnt0_r[7:0]} : // see (R10)
    hit(PADDR, `TCPS_OFF_T0HI)   ? {24'h000000, cnt0_r[15:8]} :
    hit(PADDR, `TCPS_OFF_T1LO)   ? {24'h000000, cnt1_r[7:0]} :
    hit(PADDR, `TCPS_OFF_T1HI)   ? {24'h000000, cnt1_r[15:8]} :
                                   32'h00000000;

  // ----------------------------------------------------------------
  // event pin synchronisers
  // ----------------------------------------------------------------
  assign ev_pin = {TIMER1_EVENT_PIN, TIMER0_EVENT_PIN};

  // three stages: two to resolve metastability, one more for the edge
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_sync
      always_ff @(posedge CLK_SYS)
      begin
        if (!NRST)
        begin
          ev_s1[gi] <= 1'b1;
          ev_s2[gi] <= 1'b1;
          ev_s3[gi] <= 1'b1;
        end
        else
        begin
          ev_s1[gi] <= ev_pin[gi];
          ev_s2[gi] <= ev_s1[gi];
          ev_s3[gi] <= ev_s2[gi];
        end
      end
      // edges closer than two periods can be missed
      assign ev_fall[gi] = ev_s3[gi] & ~ev_s2[gi]; // see (R15) (R16)
    end
  endgenerate

  // ----------------------------------------------------------------
  // count step: {overflow, high, low}
  // ----------------------------------------------------------------
  function automatic logic [16:0] step(input tcps_mode_t m, input logic [15:0] c);
    logic [12:0] c13;
    c13 = {c[15:8], c[4:0]} + 13'h0001;
    unique case (m)
      TCPS_M13:   step = {c[15:8] == 8'hff && c[4:0] == 5'h1f, c13[12:5], c[7:5], c13[4:0]};
      TCPS_M16:   step = {c == 16'hffff, c + 16'h0001};
      TCPS_M8REL: step = {c[7:0] == 8'hff, c[15:8], (c[7:0] == 8'hff) ? c[15:8] : c[7:0] + 8'h01};
      TCPS_SPLIT: step = {c[7:0] == 8'hff, c[15:8], c[7:0] + 8'h01};
    endcase
  endfunction

  // ----------------------------------------------------------------
  // clock selection
  // ----------------------------------------------------------------
  tcps_mode_t  m0, m1;
  logic        cm0, cm1, split0, run1;
  logic        t0_tick, t0h_tick, t1_tick;
  logic [16:0] st0, st1;
  logic        ovf0, ovf0h, ovf1;

  assign m0     = tcps_mode_t'(mode_r[1:0]); // see (R13) (R14)
  assign m1     = tcps_mode_t'(mode_r[5:4]);
  assign cm0    = mode_r[`TCPS_MODE_T0CM];
  assign cm1    = mode_r[`TCPS_MODE_T1CM];
  assign split0 = (m0 == TCPS_SPLIT);

  // timer 0 fast select drops out of the low counter in event-counter mode; the split upper byte still uses it
  assign t0_tick = tr0_r & (cm0 ? ev_fall[0] // see (R8) (R15)
                                : (cfg_r[`TCPS_CFG_T0FAST] | pif.tick)); // see (R6) (R7)
  // split upper byte borrows timer 1 run bit and stays a timer
  assign t0h_tick = split0 & tr1_r & (cfg_r[`TCPS_CFG_T0FAST] | pif.tick);
  // with timer 0 split, timer 1 runs whenever its mode is not split
  assign run1    = (split0 ? 1'b1 : tr1_r) & (m1 != TCPS_SPLIT);
  assign t1_tick = run1 & ((cm1 & ~split0) ? ev_fall[1]
                                           : (cfg_r[`TCPS_CFG_T1FAST] | pif.tick)); // see (R4) (R5)

  assign st0   = step(m0, cnt0_r);
  assign st1   = step(m1, cnt1_r);
  assign ovf0  = t0_tick & st0[16];
  assign ovf0h = t0h_tick & (cnt0_r[15:8] == 8'hff);
  assign ovf1  = t1_tick & st1[16];

  // ----------------------------------------------------------------
  // next counts and flags: software byte writes win over counting
  // ----------------------------------------------------------------
  always_comb
  begin
    cnt0_nxt = cnt0_r;
    if (t0_tick)
      cnt0_nxt = st0[15:0];
    if (t0h_tick)
      cnt0_nxt[15:8] = cnt0_r[15:8] + 8'h01;
    if (w_t0l)
      cnt0_nxt[7:0] = PWDATA[7:0]; // see (R10)
    if (w_t0h)
      cnt0_nxt[15:8] = PWDATA[7:0];
    cnt1_nxt = t1_tick ? st1[15:0] : cnt1_r;
    if (w_t1l)
      cnt1_nxt[7:0] = PWDATA[7:0];
    if (w_t1h)
      cnt1_nxt[15:8] = PWDATA[7:0];
  end

  // overflow set beats a software clear in the same cycle
  assign tf0_nxt = ovf0 | (w_ctrl ? PWDATA[`TCPS_CTRL_TF0] : tf0_r); // see (R11)
  assign tf1_nxt = (split0 ? ovf0h : ovf1)
                 | (w_ctrl ? PWDATA[`TCPS_CTRL_TF1] : tf1_r);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS)
  begin
    if (!NRST)
    begin
      cfg_r  <= `TCPS_RST_BYTE;
      mode_r <= `TCPS_RST_BYTE;
      ie_r   <= 2'b00;
      tr0_r  <= 1'b0;
      tr1_r  <= 1'b0;
      tf0_r  <= 1'b0;
      tf1_r  <= 1'b0;
      cnt0_r <= 16'h0000;
      cnt1_r <= 16'h0000;
    end
    else
    begin
      if (w_cfg)
        cfg_r <= PWDATA[7:0] & `TCPS_CFG_WMASK; // see (R1)
      if (w_mode)
        mode_r <= PWDATA[7:0] & `TCPS_MODE_WMASK; // see (R14)
      if (w_ie)
        ie_r <= PWDATA[1:0];
      if (w_ctrl)
      begin
        tr0_r <= PWDATA[`TCPS_CTRL_TR0];
        tr1_r <= PWDATA[`TCPS_CTRL_TR1];
      end
      tf0_r  <= tf0_nxt;
      tf1_r  <= tf1_nxt;
      cnt0_r <= cnt0_nxt;
      cnt1_r <= cnt1_nxt;
    end
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (!NRST)
    begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h00000000;
    end
    else
    begin
      pready_r  <= acc;
      pslverr_r <= acc & ~mapped;
      prdata_r  <= (acc & ~PWRITE & mapped) ? rd_mux : 32'h00000000;
    end
  end

  // outputs leave straight from flops
  always_ff @(posedge CLK_SYS)
  begin
    if (!NRST)
    begin
      t2l_r   <= 1'b0;
      t2h_r   <= 1'b0;
      t1ovf_r <= 1'b0;
      irq0_r  <= 1'b0;
      irq1_r  <= 1'b0;
    end
    else
    begin
      t2l_r   <= cfg_r[`TCPS_CFG_T2L] | T2_ALT_TICK; // see (R2)
      t2h_r   <= cfg_r[`TCPS_CFG_T2H] | T2_ALT_TICK; // see (R3)
      t1ovf_r <= t1_tick & st1[16];
      irq0_r  <= tf0_r & ie_r[0]; // see (R12)
      irq1_r  <= tf1_r & ie_r[1];
    end
  end

  assign PRDATA   = prdata_r;
  assign PREADY   = pready_r;
  assign PSLVERR  = pslverr_r;
  assign T2L_TICK = t2l_r;
  assign T2H_TICK = t2h_r;
  assign T1_OVF   = t1ovf_r;
  assign IRQ_T0   = irq0_r;
  assign IRQ_T1   = irq1_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_cfg_unused_zero: assert property (@(posedge CLK_SYS) disable iff (!NRST) // see (R1)
    $rose(pready_r) && !PWRITE && PADDR == `TCPS_OFF_CLKCFG |-> !PRDATA[7] && !PRDATA[2])
    else $error("clock config unused bits not zero");

  a_t0_fast_clock: assert property (@(posedge CLK_SYS) disable iff (!NRST) // see (R7)
    (tr0_r && !cm0 && cfg_r[`TCPS_CFG_T0FAST] && m0 == TCPS_M16 && !w_t0l && !w_t0h)
      |=> cnt0_r == $past(cnt0_r) + 16'h0001)
    else $error("timer 0 missed a system clock step");

  a_t0_prescaled: assert property (@(posedge CLK_SYS) disable iff (!NRST) // see (R6)
    (!cm0 && !cfg_r[`TCPS_CFG_T0FAST]) |-> t0_tick == (tr0_r && pif.tick))
    else $error("timer 0 not on prescaled clock");

  a_t0_event_only: assert property (@(posedge CLK_SYS) disable iff (!NRST) // see (R8) (R15)
    cm0 |-> t0_tick == (tr0_r && ev_s3[0] && !ev_s2[0]))
    else $error("timer 0 event mode uses wrong source");

  a_t0_pin_fall: assert property (@(posedge CLK_SYS) disable iff (!NRST) // see (R15)
    (tr0_r && cm0 && m0 == TCPS_M16 && !w_t0l && !w_t0h && $fell(ev_s2[0]))
      |=> cnt0_r == $past(cnt0_r) + 16'h0001)
    else $error("pin falling edge not counted");

  a_t1_clock_sel: assert property (@(posedge CLK_SYS) disable iff (!NRST) // see (R4) (R5)
    (tr1_r && !split0 && m1 != TCPS_SPLIT && !cm1)
      |-> t1_tick == (cfg_r[`TCPS_CFG_T1FAST] || pif.tick))
    else $error("timer 1 clock select wrong");

  a_irq_gating: assert property (@(posedge CLK_SYS) disable iff (!NRST) // see (R12)
    ##1 (IRQ_T0 == $past(tf0_r && ie_r[0])) && (IRQ_T1 == $past(tf1_r && ie_r[1])))
    else $error("interrupt not gated by its enable");

  a_flag_set_wins: assert property (@(posedge CLK_SYS) disable iff (!NRST) // see (R11)
    ovf0 |=> tf0_r)
    else $error("overflow flag lost");

  a_byte_write: assert property (@(posedge CLK_SYS) disable iff (!NRST) // see (R10) (R14)
    w_t1h |=> cnt1_r[15:8] == $past(PWDATA[7:0]) && cnt0_r[15:8] == $past(cnt0_nxt[15:8]))
    else $error("byte write not stored");

  a_t2_low_sel: assert property (@(posedge CLK_SYS) disable iff (!NRST) // see (R2) (R3)
    cfg_r[`TCPS_CFG_T2L] && cfg_r[`TCPS_CFG_T2H] |=> T2L_TICK && T2H_TICK)
    else $error("timer 2 system clock select ignored");

endmodule

// >>> tcps_top_tb_top.sv
`timescale 1ns/10ps
`include "tcps_params.svh"

module tcps_top_tb_top;
  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic        clk_sys, nrst, psel, penable, pwrite, pin0, pin1, alt_tick;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rq, q1;
  logic        pready, pslverr, re, t2l, t2h, t1_ovf, irq_t0, irq_t1;
  int          n_tests, n_mismatch, g;
  int          divs [4] = '{12, 4, 48, 8};

  tcps_top tcps_top_inst (
    .CLK_SYS(clk_sys), .NRST(nrst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .TIMER0_EVENT_PIN(pin0), .TIMER1_EVENT_PIN(pin1), .T2_ALT_TICK(alt_tick),
    .T2L_TICK(t2l), .T2H_TICK(t2h), .T1_OVF(t1_ovf), .IRQ_T0(irq_t0), .IRQ_T1(irq_t1));

  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one apb transfer, request held until pready is sampled high
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n >= 50)
      chk(32'h1, 32'h0);
    rq = prdata;
    re = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask

  // cycles between two timer 1 overflow pulses
  task automatic ovf_gap(output int gap);
    int n;
    n = 0;
    while (t1_ovf !== 1'b1 && n < 200)
    begin
      @(posedge clk_sys);
      n++;
    end
    gap = 0;
    do
    begin
      @(posedge clk_sys);
      gap++;
    end
    while (t1_ovf !== 1'b1 && gap < 200);
  endtask

  task automatic wrap_up;
    $display("counts: %0d compares, %0d mismatches", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk_sys);
    n_mismatch++;
    wrap_up();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {nrst, alt_tick} = 2'b00;
    {pin0, pin1} = 2'b11;
    n_tests = 0;
    n_mismatch = 0;
    repeat (6) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    for (int i = 0; i < 8; i++)
    begin
      xfer(1'b0, 8'(i * 4), 32'h0);
      chk(rq, 32'h0);
    end
    xfer(1'b1, `TCPS_OFF_CLKCFG, 32'hffffffff);
    xfer(1'b0, `TCPS_OFF_CLKCFG, 32'h0);
    chk(rq, 32'h7b);
    xfer(1'b1, 8'h20, 32'h55);
    chk({31'h0, re}, 32'h1);
    xfer(1'b0, 8'h22, 32'h0);
    chk({31'h0, re}, 32'h1);
    chk(rq, 32'h0);
    $display("test registers done");
    for (int c = 0; c < 8; c++)
    begin
      xfer(1'b1, `TCPS_OFF_CLKCFG, {25'h0, c[1:0], 5'h0});
      alt_tick <= c[2];
      repeat (3) @(posedge clk_sys);
      chk({31'h0, t2l}, c[0] ? 32'h1 : {31'h0, c[2]});
      chk({31'h0, t2h}, c[1] ? 32'h1 : {31'h0, c[2]});
    end
    $display("test timer 2 clock select done");
    xfer(1'b1, `TCPS_OFF_MODE, 32'hff);
    xfer(1'b0, `TCPS_OFF_MODE, 32'h0);
    chk(rq, 32'h77);
    for (int i = 0; i < 4; i++)
      xfer(1'b1, 8'(`TCPS_OFF_T0LO + 4 * i), 32'(8'h11 * (i + 1)));
    for (int i = 0; i < 4; i++)
    begin
      xfer(1'b0, 8'(`TCPS_OFF_T0LO + 4 * i), 32'h0);
      chk(rq, 32'(8'h11 * (i + 1)));
    end
    $display("test count bytes done");
    // timer 1 reloads 0xff so every tick overflows: the gap is the tick period
    xfer(1'b1, `TCPS_OFF_MODE, 32'h21);
    xfer(1'b1, `TCPS_OFF_T1LO, 32'hff);
    xfer(1'b1, `TCPS_OFF_T1HI, 32'hff);
    xfer(1'b1, `TCPS_OFF_CTRL, 32'h05);
    for (int c = 0; c < 4; c++)
    begin
      xfer(1'b1, `TCPS_OFF_CLKCFG, 32'(c));
      ovf_gap(g);
      ovf_gap(g);
      chk(32'(g), 32'(divs[c]));
    end
    xfer(1'b1, `TCPS_OFF_CLKCFG, 32'h10);
    ovf_gap(g);
    ovf_gap(g);
    chk(32'(g), 32'h1);
    // timer 1 has overflowed with its run bit set: flag and gated request follow
    xfer(1'b0, `TCPS_OFF_CTRL, 32'h0);
    chk(rq, 32'h0d);
    xfer(1'b1, `TCPS_OFF_IRQEN, 32'h2);
    repeat (2) @(posedge clk_sys);
    chk({31'h0, irq_t1}, 32'h1);
    xfer(1'b1, `TCPS_OFF_IRQEN, 32'h0);
    // back-to-back reads of timer 0 low byte are four cycles apart
    xfer(1'b1, `TCPS_OFF_CLKCFG, 32'h08);
    xfer(1'b0, `TCPS_OFF_T0LO, 32'h0);
    q1 = rq;
    xfer(1'b0, `TCPS_OFF_T0LO, 32'h0);
    chk({24'h0, rq[7:0] - q1[7:0]}, 32'h4);
    xfer(1'b1, `TCPS_OFF_CLKCFG, 32'h02);
    xfer(1'b0, `TCPS_OFF_T0LO, 32'h0);
    q1 = rq;
    // 96 cycles between the two samples hold exactly two divide-by-48 ticks
    repeat (92) @(posedge clk_sys);
    xfer(1'b0, `TCPS_OFF_T0LO, 32'h0);
    chk({24'h0, rq[7:0] - q1[7:0]}, 32'h2);
    $display("test clock sources done");
    xfer(1'b1, `TCPS_OFF_CLKCFG, 32'h08);
    xfer(1'b1, `TCPS_OFF_MODE, 32'h25);
    xfer(1'b0, `TCPS_OFF_T0LO, 32'h0);
    q1 = rq;
    xfer(1'b0, `TCPS_OFF_T0LO, 32'h0);
    chk(rq, q1);
    pin0 <= 1'b0;
    repeat (8) @(posedge clk_sys);
    pin0 <= 1'b1;
    repeat (8) @(posedge clk_sys);
    xfer(1'b0, `TCPS_OFF_T0LO, 32'h0);
    chk(rq, {24'h0, q1[7:0] + 8'h1});
    $display("test event counting done");
    xfer(1'b1, `TCPS_OFF_CTRL, 32'h0);
    for (int m = 0; m < 4; m++)
    begin
      xfer(1'b1, `TCPS_OFF_MODE, 32'(m));
      xfer(1'b1, `TCPS_OFF_T0LO, 32'h1f);
      xfer(1'b1, `TCPS_OFF_T0HI, 32'hff);
      xfer(1'b1, `TCPS_OFF_CTRL, 32'h01);
      // counter mode with a quiet pin freezes timer 0 without touching the flag
      xfer(1'b1, `TCPS_OFF_MODE, 32'(m + 4));
      xfer(1'b0, `TCPS_OFF_CTRL, 32'h0);
      chk(rq, (m == 0) ? 32'h3 : 32'h1);
      xfer(1'b0, `TCPS_OFF_T0HI, 32'h0);
      chk(rq, (m == 0) ? 32'h0 : 32'hff);
      chk({31'h0, irq_t0}, 32'h0);
      xfer(1'b1, `TCPS_OFF_IRQEN, 32'h1);
      repeat (2) @(posedge clk_sys);
      chk({31'h0, irq_t0}, (m == 0) ? 32'h1 : 32'h0);
      chk({31'h0, irq_t1}, 32'h0);
      xfer(1'b1, `TCPS_OFF_IRQEN, 32'h0);
      xfer(1'b1, `TCPS_OFF_CTRL, 32'h0);
    end
    $display("test modes and interrupts done");
    wrap_up();
  end
endmodule
